// ===== rtl/ddac_pkg.sv
// ddac_pkg: constants and types shared by both ends of the two-wire link.
// assumes one 50 MHz system clock at each end and a 7-bit target address.
// Operation
// - two data bytes fill the selected register
// - write applies at falling edge ending acknowledge
// - controller opens read with address, write direction
// - command byte names register; target acknowledges
// - repeated start, read direction; target acknowledges
// - target sends high data byte first
// - controller acknowledges the high byte
// - low byte last; controller does not acknowledge
// - read without command returns last written register
// - all registers readable except trigger field
// - channel A code held left aligned
// - channel B code held left aligned
// - offset zero write changes nothing but the last written register
// - broadcast enable bits gate broadcast updates
// - sync enable defers update to load trigger
// - power-down bit per channel
// - reference power-down bit
package ddac_pkg;
  // target register indices
  localparam logic [3:0]  DDAC_REG_NO_OPERATION   = 4'h0;
  localparam logic [3:0]  DDAC_REG_DEVICE_IDENTIFICATION  = 4'h1;
  localparam logic [3:0]  DDAC_REG_SYNC   = 4'h2;
  localparam logic [3:0]  DDAC_REG_CONFIG = 4'h3;
  localparam logic [3:0]  DDAC_REG_GAIN   = 4'h4;
  localparam logic [3:0]  DDAC_REG_TRIG   = 4'h5;
  localparam logic [3:0]  DDAC_REG_BCAST  = 4'h6;
  localparam logic [3:0]  DDAC_REG_STAT   = 4'h7;
  localparam logic [3:0]  DDAC_REG_CH_A   = 4'h8;
  // reset values and identity
  localparam logic [15:0] DDAC_SYNC_RST   = 16'h0300;
  localparam logic [15:0] DDAC_CONFIG_RST = 16'h0000;
  localparam logic [15:0] DDAC_GAIN_RST   = 16'h0003;
  localparam logic [15:0] DDAC_ZERO16     = 16'h0000;
  localparam logic [15:0] DDAC_DEVICE_IDENTIFICATION      = 16'h0ABC; // arbitrary value
  // field positions
  localparam int          DDAC_SYNC_EN_LSB  = 0;
  localparam int          DDAC_BCAST_EN_LSB = 8;
  localparam int          DDAC_PD_LSB       = 0;
  localparam int          DDAC_REF_PD_BIT   = 8;
  localparam int          DDAC_LOAD_BIT     = 4;
  localparam int          DDAC_ALARM_BIT    = 0;
  localparam int          DDAC_RES_BITS     = 16;
  localparam logic [15:0] DDAC_CODE_MASK    = 16'(16'hFFFF << (16 - DDAC_RES_BITS));
  // link address and timing
  localparam logic [6:0]  DDAC_TGT_ADDR = 7'h48;
  localparam int          DDAC_CLK_HZ   = 50_000_000;
  localparam int          DDAC_SCL_HZ   = 400_000;
  localparam int          DDAC_QTR_CYC  = DDAC_CLK_HZ / (4 * DDAC_SCL_HZ);
  localparam logic [5:0]  DDAC_QTR_LAST = 6'(DDAC_QTR_CYC - 1);
  // controller wishbone byte addresses
  localparam logic [7:0]  DDAC_WB_CMD      = 8'h00;
  localparam logic [7:0]  DDAC_WB_WDATA    = 8'h04;
  localparam logic [7:0]  DDAC_WB_RDATA    = 8'h08;
  localparam logic [7:0]  DDAC_WB_STATUS   = 8'h0C;
  localparam logic [7:0]  DDAC_WB_IRQ_STAT = 8'h10;
  localparam logic [7:0]  DDAC_WB_IRQ_CLR  = 8'h14;
  localparam logic [7:0]  DDAC_WB_IRQ_EN   = 8'h18;
  localparam int          DDAC_CMD_OP_LSB  = 8;
  localparam int          DDAC_ST_BUSY_BIT = 0;
  localparam int          DDAC_ST_NACK_BIT = 1;
  localparam int          DDAC_IRQ_DONE    = 0;
  localparam int          DDAC_IRQ_NACK    = 1;

  typedef enum logic [1:0] {
    DDAC_OP_WRITE = 2'b00,
    DDAC_OP_READ  = 2'b01,
    DDAC_OP_LAST  = 2'b10
  } ddac_op_t;

  typedef enum logic [1:0] {
    DDAC_T_IDLE = 2'b00,
    DDAC_T_ADDR = 2'b01,
    DDAC_T_WR   = 2'b10,
    DDAC_T_RD   = 2'b11
  } ddac_tmode_t;

  typedef enum logic [1:0] {
    DDAC_C_IDLE  = 2'b00,
    DDAC_C_START = 2'b01,
    DDAC_C_BYTE  = 2'b10,
    DDAC_C_STOP  = 2'b11
  } ddac_cstate_t;
endpackage

// ===== rtl/ddac_if.sv
// ddac_if: two-wire link between controller and target.
// assumes scl is pushed by the controller only; sda is open drain.
interface ddac_if;
  logic scl;
  logic ctl_sda_o;
  logic ctl_sda_oe_n;
  logic tgt_sda_o;
  logic tgt_sda_oe_n;
  logic sda;

  // wired-and of both open-drain drivers, released means high
  assign sda = (ctl_sda_oe_n | ctl_sda_o) & (tgt_sda_oe_n | tgt_sda_o);

  modport ctl (output scl, output ctl_sda_o, output ctl_sda_oe_n, input sda);
  modport tgt (input scl, input sda, output tgt_sda_o, output tgt_sda_oe_n);
endinterface

// ===== rtl/ddac_target.sv
// ddac_target: register access end of the dual converter on the two-wire link.
// assumes scl and sda are asynchronous; both pass two flops before use.
module ddac_target
  import ddac_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // link
  ddac_if.tgt              lnk,
  // analogue side
  input  wire logic        ref_alarm_i,
  output logic      [15:0] ch_a_code_o,
  output logic      [15:0] ch_b_code_o,
  output logic      [1:0]  ch_power_down_o,
  output logic             reference_power_down_o,
  output logic      [15:0] output_gain_o
);
  logic        scl_m;
  logic        scl_s;
  logic        scl_p;
  logic        sda_m;
  logic        sda_s;
  logic        sda_p;
  logic        alarm_m;
  logic        alarm_s;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  ddac_tmode_t mode;
  logic [3:0]  cnt;
  logic [7:0]  rx;
  logic [1:0]  byte_no;
  logic [7:0]  hi;
  logic [3:0]  ptr;
  logic [3:0]  last_wr;
  logic        cmd_seen;
  logic [15:0] tx;
  logic        rd_lo;
  logic        nack;
  logic        oe_n;
  logic        commit;
  logic        load;
  logic [15:0] wd;
  logic [15:0] rd_src;
  logic [3:0]  tx_idx;
  logic [15:0] sync_q;
  logic [15:0] cfg_q;
  logic [15:0] gain_q;
  logic [15:0] bcast_q;

  // edges found on the second flop against a third
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_m   <= 1'b1;
      scl_s   <= 1'b1;
      scl_p   <= 1'b1;
      sda_m   <= 1'b1;
      sda_s   <= 1'b1;
      sda_p   <= 1'b1;
      alarm_m <= 1'b0;
      alarm_s <= 1'b0;
    end else if (ce_i) begin
      scl_m   <= lnk.scl;
      scl_s   <= scl_m;
      scl_p   <= scl_s;
      sda_m   <= lnk.sda;
      sda_s   <= sda_m;
      sda_p   <= sda_s;
      alarm_m <= ref_alarm_i;
      alarm_s <= alarm_m;
    end
  end

  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign start_c  = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_c   = scl_s & scl_p & ~sda_p & sda_s;
  assign wd       = {hi, rx};
  // only the fall that closes the low byte acknowledge commits
  assign commit   = ce_i & scl_fall & (cnt == 4'h9) & (mode == DDAC_T_WR) & (byte_no == 2'h2);
  assign load     = commit & (ptr == DDAC_REG_TRIG) & wd[DDAC_LOAD_BIT];
  assign tx_idx   = {~rd_lo, 3'(3'h7 - cnt[2:0])};

  // register read mux
  always_comb begin
    rd_src = DDAC_ZERO16;
    unique case (cmd_seen ? ptr : last_wr)
      DDAC_REG_DEVICE_IDENTIFICATION:        rd_src = DDAC_DEVICE_IDENTIFICATION;
      DDAC_REG_SYNC:         rd_src = sync_q;
      DDAC_REG_CONFIG:       rd_src = cfg_q;
      DDAC_REG_GAIN:         rd_src = gain_q;
      DDAC_REG_BCAST:        rd_src = bcast_q;
      DDAC_REG_STAT:         rd_src[DDAC_ALARM_BIT] = alarm_s;
      DDAC_REG_CH_A:         rd_src = g_ch[0].buf_q;
      DDAC_REG_CH_A + 4'h1:  rd_src = g_ch[1].buf_q;
      default:               rd_src = DDAC_ZERO16;
    endcase
  end

  // link protocol
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode     <= DDAC_T_IDLE;
      cnt      <= 4'h0;
      rx       <= 8'h00;
      byte_no  <= 2'h0;
      hi       <= 8'h00;
      ptr      <= 4'h0;
      last_wr  <= 4'h0;
      cmd_seen <= 1'b0;
      tx       <= 16'h0000;
      rd_lo    <= 1'b0;
      nack     <= 1'b0;
      oe_n     <= 1'b1;
    end else if (ce_i) begin
      if (stop_c) begin
        mode     <= DDAC_T_IDLE;
        oe_n     <= 1'b1;
        cmd_seen <= 1'b0;
      end else if (start_c) begin
        mode <= DDAC_T_ADDR;
        cnt  <= 4'h0;
        oe_n <= 1'b1;
      end else if (mode != DDAC_T_IDLE) begin
        if (scl_rise) begin
          if (cnt < 4'h8) begin
            rx <= {rx[6:0], sda_s};
          end else begin
            nack <= sda_s;
          end
          cnt <= cnt + 4'h1;
        end
        if (scl_fall) begin
          if (cnt == 4'h8) begin
            unique case (mode)
              DDAC_T_ADDR: begin
                if (rx[7:1] == DDAC_TGT_ADDR) begin
                  oe_n <= 1'b0;
                end else begin
                  mode <= DDAC_T_IDLE;
                end
              end
              DDAC_T_WR:   oe_n <= 1'b0;
              DDAC_T_RD:   oe_n <= 1'b1;
              DDAC_T_IDLE: oe_n <= 1'b1;
            endcase
          end else if (cnt == 4'h9) begin
            cnt  <= 4'h0;
            oe_n <= 1'b1;
            unique case (mode)
              DDAC_T_ADDR: begin
                if (rx[0]) begin
                  mode  <= DDAC_T_RD;
                  tx    <= rd_src;
                  rd_lo <= 1'b0;
                  oe_n  <= rd_src[15];
                end else begin
                  mode    <= DDAC_T_WR;
                  byte_no <= 2'h0;
                end
              end
              DDAC_T_WR: begin
                unique case (byte_no)
                  2'h0: begin
                    ptr      <= rx[3:0];
                    cmd_seen <= 1'b1;
                    byte_no  <= 2'h1;
                  end
                  2'h1: begin
                    hi      <= rx;
                    byte_no <= 2'h2;
                  end
                  default: begin
                    last_wr <= ptr;
                    byte_no <= 2'h1;
                  end
                endcase
              end
              DDAC_T_RD: begin
                if (nack) begin
                  mode <= DDAC_T_IDLE;
                end else begin
                  rd_lo <= 1'b1;
                  oe_n  <= tx[7];
                end
              end
              DDAC_T_IDLE: oe_n <= 1'b1;
            endcase
          end else if (mode == DDAC_T_RD) begin
            oe_n <= tx[tx_idx];
          end
        end
      end
    end
  end

  // control registers; offset zero and trigger hold nothing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_q  <= DDAC_SYNC_RST;
      cfg_q   <= DDAC_CONFIG_RST;
      gain_q  <= DDAC_GAIN_RST;
      bcast_q <= DDAC_ZERO16;
    end else if (commit) begin
      unique case (ptr)
        DDAC_REG_SYNC:   sync_q  <= wd;
        DDAC_REG_CONFIG: cfg_q   <= wd;
        DDAC_REG_GAIN:   gain_q  <= wd;
        DDAC_REG_BCAST:  bcast_q <= wd & DDAC_CODE_MASK;
        default:         sync_q  <= sync_q;
      endcase
    end
  end

  // per channel code: buffered value and applied value
  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic        hit;
    logic [15:0] buf_q;
    logic [15:0] code_q;

    assign hit = commit & ((ptr == 4'(DDAC_REG_CH_A + 4'(i)))
                 | ((ptr == DDAC_REG_BCAST) & sync_q[DDAC_BCAST_EN_LSB + i]));

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        buf_q  <= DDAC_ZERO16;
        code_q <= DDAC_ZERO16;
      end else begin
        if (hit) begin
          buf_q <= wd & DDAC_CODE_MASK;
        end
        if (hit & ~sync_q[DDAC_SYNC_EN_LSB + i]) begin
          code_q <= wd & DDAC_CODE_MASK;
        end else if (load & sync_q[DDAC_SYNC_EN_LSB + i]) begin
          code_q <= buf_q;
        end
      end
    end
  end

  assign ch_a_code_o            = g_ch[0].code_q;
  assign ch_b_code_o            = g_ch[1].code_q;
  assign ch_power_down_o        = cfg_q[DDAC_PD_LSB +: 2];
  assign reference_power_down_o = cfg_q[DDAC_REF_PD_BIT];
  assign output_gain_o          = gain_q;
  assign lnk.tgt_sda_o          = 1'b0;
  assign lnk.tgt_sda_oe_n       = oe_n;
endmodule

// ===== rtl/ddac_ctrl.sv
// ddac_ctrl: two-wire bus controller run from classic wishbone registers.
// assumes the target answers with plain acknowledges and no clock stretching.
module ddac_ctrl
  import ddac_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // interrupt
  output logic             irq_o,
  // link
  ddac_if.ctl              lnk
);
  logic         wb_go;
  logic         wr_go;
  logic         cmd_go;
  logic [31:0]  rd_v;
  logic [15:0]  wdata;
  logic [15:0]  rdata;
  logic [3:0]   ptr;
  ddac_op_t     op;
  logic         busy;
  logic         nack_f;
  logic [1:0]   irq_st;
  logic [1:0]   irq_en;
  logic [1:0]   irq_set;
  logic [1:0]   irq_clr;
  logic [1:0]   next_irq_st;
  ddac_cstate_t st;
  logic [1:0]   q;
  logic [5:0]   qc;
  logic         tick;
  logic [3:0]   seg;
  logic [3:0]   bitc;
  logic [8:0]   tx;
  logic [8:0]   rx;
  logic         rd_byte;
  logic         scl_q;
  logic         oe_n_q;
  logic         sda_m;
  logic         sda_s;
  logic [10:0]  nxt;
  logic         done_p;
  logic         nack_p;

  // one step of a transfer: state code and nine bits to send
  function automatic logic [10:0] seg_of(ddac_op_t o, logic [3:0] s, logic [3:0] p, logic [15:0] d);
    logic [10:0] aw;
    logic [10:0] ar;
    logic [10:0] cm;
    logic [10:0] sb;
    logic [10:0] pb;
    aw = {DDAC_C_BYTE, DDAC_TGT_ADDR, 1'b0, 1'b1};
    ar = {DDAC_C_BYTE, DDAC_TGT_ADDR, 1'b1, 1'b1};
    cm = {DDAC_C_BYTE, 4'h0, p, 1'b1};
    sb = {DDAC_C_START, 9'h1FF};
    pb = {DDAC_C_STOP, 9'h1FF};
    seg_of = pb;
    case (o)
      DDAC_OP_WRITE: begin
        case (s)
          4'h0:    seg_of = sb;
          4'h1:    seg_of = aw;
          4'h2:    seg_of = cm;
          4'h3:    seg_of = {DDAC_C_BYTE, d[15:8], 1'b1};
          4'h4:    seg_of = {DDAC_C_BYTE, d[7:0], 1'b1};
          default: seg_of = pb;
        endcase
      end
      DDAC_OP_READ: begin
        case (s)
          4'h0:    seg_of = sb;
          4'h1:    seg_of = aw;
          4'h2:    seg_of = cm;
          4'h3:    seg_of = sb;
          4'h4:    seg_of = ar;
          4'h5:    seg_of = {DDAC_C_BYTE, 8'hFF, 1'b0};
          4'h6:    seg_of = {DDAC_C_BYTE, 8'hFF, 1'b1};
          default: seg_of = pb;
        endcase
      end
      DDAC_OP_LAST: begin
        case (s)
          4'h0:    seg_of = sb;
          4'h1:    seg_of = ar;
          4'h2:    seg_of = {DDAC_C_BYTE, 8'hFF, 1'b0};
          4'h3:    seg_of = {DDAC_C_BYTE, 8'hFF, 1'b1};
          default: seg_of = pb;
        endcase
      end
      default: seg_of = pb;
    endcase
  endfunction

  assign wb_go   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_go   = wb_go & wb_we_i;
  assign cmd_go  = wr_go & (wb_adr_i == DDAC_WB_CMD) & wb_sel_i[0] & ~busy;
  assign tick    = (qc == DDAC_QTR_LAST);
  assign nxt     = seg_of(op, seg + 4'h1, ptr, wdata);
  assign irq_clr = (wr_go & (wb_adr_i == DDAC_WB_IRQ_CLR) & wb_sel_i[0]) ? wb_dat_i[1:0] : 2'h0;

  // a new event wins over a clear in the same cycle
  always_comb begin
    irq_set                = 2'h0;
    irq_set[DDAC_IRQ_DONE] = done_p;
    irq_set[DDAC_IRQ_NACK] = nack_p;
    next_irq_st            = (irq_st & ~irq_clr) | irq_set;
  end

  always_comb begin
    rd_v = 32'h0000_0000;
    unique case (wb_adr_i)
      DDAC_WB_CMD: begin
        rd_v[3:0]                    = ptr;
        rd_v[DDAC_CMD_OP_LSB +: 2]   = op;
      end
      DDAC_WB_WDATA:    rd_v[15:0] = wdata;
      DDAC_WB_RDATA:    rd_v[15:0] = rdata;
      DDAC_WB_STATUS: begin
        rd_v[DDAC_ST_BUSY_BIT] = busy;
        rd_v[DDAC_ST_NACK_BIT] = nack_f;
      end
      DDAC_WB_IRQ_STAT: rd_v[1:0] = irq_st;
      DDAC_WB_IRQ_EN:   rd_v[1:0] = irq_en;
      default:          rd_v = 32'h0000_0000;
    endcase
  end

  // bus answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= wb_go;
      wb_dat_o <= (wb_go & ~wb_we_i) ? rd_v : 32'h0000_0000;
    end
  end

  // software registers and interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdata  <= 16'h0000;
      ptr    <= 4'h0;
      op     <= DDAC_OP_WRITE;
      irq_en <= 2'h0;
      irq_st <= 2'h0;
      irq_o  <= 1'b0;
    end else if (ce_i) begin
      if (wr_go & (wb_adr_i == DDAC_WB_WDATA)) begin
        if (wb_sel_i[0]) wdata[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) wdata[15:8] <= wb_dat_i[15:8];
      end
      if (wr_go & (wb_adr_i == DDAC_WB_IRQ_EN) & wb_sel_i[0]) begin
        irq_en <= wb_dat_i[1:0];
      end
      if (cmd_go) begin
        ptr <= wb_dat_i[3:0];
        op  <= ddac_op_t'(wb_dat_i[DDAC_CMD_OP_LSB +: 2]);
      end
      irq_st <= next_irq_st;
      irq_o  <= |(next_irq_st & irq_en);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else if (ce_i) begin
      sda_m <= lnk.sda;
      sda_s <= sda_m;
    end
  end

  // link engine: four quarter phases per start, bit and stop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st      <= DDAC_C_IDLE;
      q       <= 2'h0;
      qc      <= 6'h00;
      seg     <= 4'h0;
      bitc    <= 4'h0;
      tx      <= 9'h1FF;
      rx      <= 9'h000;
      rd_byte <= 1'b0;
      scl_q   <= 1'b1;
      oe_n_q  <= 1'b1;
      busy    <= 1'b0;
      nack_f  <= 1'b0;
      rdata   <= 16'h0000;
      done_p  <= 1'b0;
      nack_p  <= 1'b0;
    end else if (ce_i) begin
      done_p <= 1'b0;
      nack_p <= 1'b0;
      qc     <= tick ? 6'h00 : qc + 6'h01;
      if (cmd_go) begin
        busy   <= 1'b1;
        nack_f <= 1'b0;
        st     <= DDAC_C_START;
        seg    <= 4'h0;
        q      <= 2'h0;
      end else if (tick && (st != DDAC_C_IDLE)) begin
        q <= q + 2'h1;
        unique case (st)
          DDAC_C_START: begin
            unique case (q)
              2'h0: begin
                scl_q  <= 1'b0;
                oe_n_q <= 1'b1;
              end
              2'h1: scl_q <= 1'b1;
              2'h2: oe_n_q <= 1'b0;
              2'h3: begin
                scl_q   <= 1'b0;
                seg     <= seg + 4'h1;
                bitc    <= 4'h0;
                tx      <= nxt[8:0];
                rd_byte <= (op != DDAC_OP_WRITE) & (nxt[8:1] == 8'hFF);
                st      <= ddac_cstate_t'(nxt[10:9]);
              end
            endcase
          end
          DDAC_C_BYTE: begin
            unique case (q)
              2'h0: oe_n_q <= tx[8];
              2'h1: scl_q <= 1'b1;
              2'h2: rx <= {rx[7:0], sda_s};
              2'h3: begin
                scl_q <= 1'b0;
                tx    <= {tx[7:0], 1'b1};
                bitc  <= bitc + 4'h1;
                if (bitc == 4'h8) begin
                  // a refused byte ends the transfer with a stop
                  if (~rd_byte & rx[0]) begin
                    st     <= DDAC_C_STOP;
                    nack_f <= 1'b1;
                    nack_p <= 1'b1;
                  end else begin
                    if (rd_byte) rdata <= {rdata[7:0], rx[8:1]};
                    seg     <= seg + 4'h1;
                    bitc    <= 4'h0;
                    tx      <= nxt[8:0];
                    rd_byte <= (op != DDAC_OP_WRITE) & (nxt[8:1] == 8'hFF);
                    st      <= ddac_cstate_t'(nxt[10:9]);
                  end
                end
              end
            endcase
          end
          DDAC_C_STOP: begin
            unique case (q)
              2'h0: begin
                scl_q  <= 1'b0;
                oe_n_q <= 1'b0;
              end
              2'h1: scl_q <= 1'b1;
              2'h2: oe_n_q <= 1'b1;
              2'h3: begin
                st     <= DDAC_C_IDLE;
                busy   <= 1'b0;
                done_p <= 1'b1;
              end
            endcase
          end
          DDAC_C_IDLE: st <= DDAC_C_IDLE;
        endcase
      end
    end
  end

  assign lnk.scl          = scl_q;
  assign lnk.ctl_sda_o    = 1'b0;
  assign lnk.ctl_sda_oe_n = oe_n_q;
endmodule

// ===== sim/ddac_monitor.sv
// ddac_monitor: wire-level checks on the two-wire link between both ends.
// assumes one clock domain and a synchronous active-high reset.
module ddac_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link
  input wire logic scl,
  input wire logic ctl_sda_o,
  input wire logic ctl_sda_oe_n,
  input wire logic tgt_sda_o,
  input wire logic tgt_sda_oe_n,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  reset_idle_a: assert property ($fell(rst_i) |-> scl && ctl_sda_oe_n && tgt_sda_oe_n)
    else $error("link not idle after reset");
  open_drain_a: assert property (ctl_sda_o == 1'b0 && tgt_sda_o == 1'b0)
    else $error("sda driven high");
  idle_high_a: assert property (ctl_sda_oe_n && tgt_sda_oe_n |-> sda)
    else $error("released sda not high");
  tgt_stable_a: assert property (scl && $past(scl) |-> $stable(tgt_sda_oe_n))
    else $error("target moved sda while scl high");
  scl_high_a: assert property ($rose(scl) |-> scl[*8])
    else $error("scl high phase too short");
  scl_low_a: assert property ($fell(scl) |-> (!scl)[*8])
    else $error("scl low phase too short");
  ack_start_a: assert property ($fell(tgt_sda_oe_n) |-> !scl)
    else $error("target took sda while scl high");
  start_ctl_a: assert property (scl && $past(scl) && $fell(sda) |-> !ctl_sda_oe_n)
    else $error("start not made by controller");

  // main scenarios reached
  cover property ($fell(tgt_sda_oe_n));
  cover property (scl && $fell(sda));
  cover property (scl && $rose(sda));
endmodule

// ===== sim/test_dual_dac_i2c_register_access.sv
// test_dual_dac_i2c_register_access: controller and target joined, run over wishbone.
// assumes the whole run ends well inside the cycle ceiling.
module test_dual_dac_i2c_register_access import ddac_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_rd;
  logic        wb_ack;
  logic        irq;
  logic        alarm = 1'b0;
  logic        ien = 1'b1;
  logic [15:0] ch_a;
  logic [15:0] ch_b;
  logic [1:0]  pd;
  logic        ref_pd;
  logic [31:0] q;
  int          failures = 0;
  int          compares = 0;
  int          cycles = 0;

  ddac_if lnk();
  ddac_ctrl i_ddac_ctrl (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_rd),
    .wb_ack_o(wb_ack), .irq_o(irq), .lnk(lnk));
  ddac_target i_ddac_target (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .lnk(lnk), .ref_alarm_i(alarm),
    .ch_a_code_o(ch_a), .ch_b_code_o(ch_b), .ch_power_down_o(pd), .reference_power_down_o(ref_pd),
    .output_gain_o());
  ddac_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .scl(lnk.scl), .ctl_sda_o(lnk.ctl_sda_o),
    .ctl_sda_oe_n(lnk.ctl_sda_oe_n), .tgt_sda_o(lnk.tgt_sda_o), .tgt_sda_oe_n(lnk.tgt_sda_oe_n),
    .sda(lnk.sda));

  always #10 clk_i = ~clk_i;

  // a stuck transfer would otherwise hang the run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      results();
    end
  end

  task automatic results();
    if (failures == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= d;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    r = wb_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask

  // one transfer, then poll busy and settle the interrupt
  task automatic op(input logic [1:0] o, input logic [3:0] r, input logic [15:0] d);
    logic [31:0] s;
    wb(1'b1, DDAC_WB_WDATA, {16'h0, d}, s);
    wb(1'b1, DDAC_WB_CMD, {22'h0, o, 4'h0, r}, s);
    do wb(1'b0, DDAC_WB_STATUS, 32'h0, s); while (s[0] !== 1'b0);
    chk("status", s[15:0], 16'h0000);
    chk("irq", {15'h0, irq}, {15'h0, ien});
    wb(1'b0, DDAC_WB_IRQ_STAT, 32'h0, s);
    chk("irq_stat", s[15:0], 16'h0001);
    wb(1'b1, DDAC_WB_IRQ_CLR, 32'h3, s);
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("ch_a", ch_a, 16'h0000);
    wb(1'b1, DDAC_WB_IRQ_EN, 32'h1, q);
    op(2'd0, 4'h8, 16'h8001);
    chk("ch_a", ch_a, 16'h8001);
    op(2'd1, 4'h8, 16'h0000);
    wb(1'b0, DDAC_WB_RDATA, 32'h0, q);
    chk("read_a", q[15:0], 16'h8001);
    op(2'd0, 4'h3, 16'h0103);
    chk("pd", {14'h0, pd}, 16'h0003);
    chk("ref_pd", {15'h0, ref_pd}, 16'h0001);
    alarm <= 1'b1;
    op(2'd1, 4'h7, 16'h0000);
    wb(1'b0, DDAC_WB_RDATA, 32'h0, q);
    chk("dev_status", q[15:0], 16'h0001);
    op(2'd0, 4'h2, 16'h0002);
    op(2'd0, 4'h9, 16'h1234);
    chk("ch_b", ch_b, 16'h0000);
    op(2'd0, 4'h5, 16'h0010);
    chk("ch_b", ch_b, 16'h1234);
    op(2'd0, 4'h2, 16'h0100);
    op(2'd0, 4'h6, 16'hABCD);
    chk("ch_a", ch_a, 16'hABCD);
    chk("ch_b", ch_b, 16'h1234);
    // interrupt masked from here on
    wb(1'b1, DDAC_WB_IRQ_EN, 32'h0, q);
    ien = 1'b0;
    op(2'd2, 4'h0, 16'h0000);
    wb(1'b0, DDAC_WB_RDATA, 32'h0, q);
    chk("read_last", q[15:0], 16'hABCD);
    op(2'd0, 4'h0, 16'hFFFF);
    chk("ch_a", ch_a, 16'hABCD);
    chk("pd", {14'h0, pd}, 16'h0003);
    wb(1'b0, 8'h1C, 32'h0, q);
    chk("unmapped", q[15:0], 16'h0000);
    results();
  end
endmodule
